// >>> swr_pkg.sv
// Package for the sleep, wake-up and reset controller.
// Assumes a single 50 MHz reference clock and an AXI4-Lite register bus.
package swr_pkg;
  // Register byte offsets.
  localparam logic [3:0] SWR_CTRL_OFS = 4'h0;
  localparam logic [3:0] SWR_STAT_OFS = 4'h4;
  localparam logic [3:0] SWR_PINEN_OFS = 4'h8;
  // Control register fields.
  localparam int SWR_WAKE_SEL_BIT = 5;
  localparam int SWR_CMPWK_BIT = 6;
  // Number of wake pins.
  localparam int SWR_NPIN = 16;
  // Wake delays in low-speed oscillator periods.
  localparam logic [11:0] SWR_NORMAL_WAKE = 12'hBB8;
  localparam logic [11:0] SWR_FAST_WAKE = 12'h02D;
  // Low-speed oscillator tick divider, 50 MHz / 64.
  localparam logic [5:0] SWR_LS_DIV = 6'h3F;
  // Restart address after any reset.
  localparam logic [15:0] SWR_RESET_PC = 16'h0000;
  // Reset values.
  localparam logic [7:0] SWR_CTRL_RST = 8'h00;
  localparam logic [15:0] SWR_PINEN_RST = 16'h0000;
  // AXI responses.
  localparam logic [1:0] SWR_RESP_OK = 2'h0;
  localparam logic [1:0] SWR_RESP_ERR = 2'h2;
  // Power states.
  typedef enum logic [1:0] {SWR_ON, SWR_SAVE, SWR_DOWN, SWR_WAKE} swr_mode_t;
endpackage

// >>> swr_ctrl.sv
// Sleep, wake-up and reset controller core with AXI4-Lite registers.
// Assumes the core, pins and timer inputs are synchronous to ref_clk.
// Functional notes
// - Deep power-down stops both RC oscillators.
// - Deep power-down switches code memory off.
// - Deep power-down keeps SRAM and registers.
// - Deep power-down wakes only on enabled pins.
// - Pin wake resumes after the sleep instruction.
// - Timer wake only in light power-save.
// - Comparator wake only in light power-save.
// - Normal wake waits 3000 low-speed clocks.
// - Fast wake waits 45 low-speed clocks.
// - Fast boot option forces fast wake.
// - Otherwise control bit five selects wake.
// - Any enabled input pin change wakes device.
// - Reset restores defaults, restarts at zero.
// - Pin or watchdog reset keeps SRAM.
// - Light power-save gates system clock and code memory.
// - Off-system-clock timer match wakes light save.
`timescale 1ns/10ps
`default_nettype none
module swr_ctrl
  import swr_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Build option and reset cause.
  input wire logic fast_boot,
  input wire logic reset_keep_cause,
  // Core sleep requests.
  input wire logic save_req,
  input wire logic down_req,
  // Wake sources.
  input wire logic [SWR_NPIN-1:0] wake_pins,
  input wire logic [SWR_NPIN-1:0] pin_is_input,
  input wire logic timer_match,
  input wire logic timer_off_sysclk,
  input wire logic cmp_event,
  // Power controls.
  output logic sys_clk_en,
  output logic high_speed_rc_osc_en,
  output logic low_speed_rc_osc_en,
  output logic programmable_code_memory_en,
  output logic sram_clear,
  output logic resume_pulse,
  output logic [15:0] restart_pc,
  // AXI4-Lite slave.
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // All state of the block in one record.
  typedef struct packed {
    swr_mode_t mode;
    logic deep;
    logic [SWR_NPIN-1:0] sync1;
    logic [SWR_NPIN-1:0] sync2;
    logic [SWR_NPIN-1:0] snap;
    logic [5:0] div;
    logic [11:0] wcnt;
    logic [11:0] wlim;
    logic [7:0] ctrl;
    logic [SWR_NPIN-1:0] pinen;
    logic [1:0] last_src;
    logic sysclk;
    logic hs_en;
    logic ls_en;
    logic mem_en;
    logic sram_clr;
    logic resume;
    logic [15:0] pc;
    logic aw_got;
    logic [3:0] aw_a;
    logic w_got;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // Registered ready flags for the address and data channels.
    logic awready;
    logic wready;
  } swr_state_t;

  swr_state_t st;
  swr_state_t next_st;

  // Wake qualifiers, kept outside the record since they are combinational in it and the inputs.
  logic [SWR_NPIN-1:0] pin_change;
  logic pin_wake;
  logic save_wake;
  logic fast_sel;
  logic [31:0] stat_word;

  // Per-pin change detect against the snapshot; only enabled inputs count.
  genvar gi;
  generate
    for (gi = 0; gi < SWR_NPIN; gi++) begin : g_pin
      assign pin_change[gi] = st.pinen[gi] & pin_is_input[gi]
                              & (st.sync2[gi] ^ st.snap[gi]);
    end
  endgenerate

  assign pin_wake = |pin_change;
  // Timer and comparator wake count only when the block is in light save.
  assign save_wake = (timer_match & timer_off_sysclk)
                     | (cmp_event & st.ctrl[SWR_CMPWK_BIT]);
  // Build option overrides the select bit.
  assign fast_sel = fast_boot | st.ctrl[SWR_WAKE_SEL_BIT];

  // Status word shows mode, deep flag and last wake source.
  assign stat_word = {26'h0, st.last_src, st.deep, 1'b0, st.mode};

  // Next-state logic for power sequencing and the register slave.
  always_comb begin
    next_st = st;
    next_st.resume = 1'b0;
    next_st.sram_clr = 1'b0;
    next_st.sync1 = wake_pins;
    next_st.sync2 = st.sync1;
    // Low-speed oscillator tick only while it runs.
    if (st.ls_en) begin
      next_st.div = st.div + 6'h01;
    end
    case (st.mode)
      SWR_ON: begin
        next_st.snap = st.sync2;
        if (down_req) begin
          next_st.mode = SWR_DOWN;
          next_st.deep = 1'b1;
          next_st.sysclk = 1'b0;
          next_st.hs_en = 1'b0;
          next_st.ls_en = 1'b0;
          next_st.mem_en = 1'b0;
        end else if (save_req) begin
          next_st.mode = SWR_SAVE;
          next_st.deep = 1'b0;
          next_st.sysclk = 1'b0;
          next_st.mem_en = 1'b0;
        end
      end
      SWR_SAVE: begin
        // Oscillators untouched here, only the system clock and code memory are off.
        if (pin_wake || save_wake) begin
          next_st.mode = SWR_WAKE;
          next_st.last_src = pin_wake ? 2'h1 : 2'h2;
          next_st.wcnt = 12'h000;
          next_st.div = 6'h00;
          next_st.wlim = fast_sel ? SWR_FAST_WAKE : SWR_NORMAL_WAKE;
        end
      end
      SWR_DOWN: begin
        // Timer and comparator are ignored; registers held as they are.
        if (pin_wake) begin
          next_st.mode = SWR_WAKE;
          next_st.last_src = 2'h1;
          next_st.wcnt = 12'h000;
          next_st.div = 6'h00;
          next_st.ls_en = 1'b1;
          next_st.hs_en = 1'b1;
          next_st.wlim = fast_sel ? SWR_FAST_WAKE : SWR_NORMAL_WAKE;
        end
      end
      SWR_WAKE: begin
        // Count low-speed periods; release only at the terminal count.
        if (st.div == SWR_LS_DIV) begin
          if (st.wcnt == st.wlim - 12'h001) begin
            next_st.mode = SWR_ON;
            next_st.deep = 1'b0;
            next_st.sysclk = 1'b1;
            next_st.mem_en = 1'b1;
            next_st.resume = 1'b1;
          end else begin
            next_st.wcnt = st.wcnt + 12'h001;
          end
        end
      end
      default: next_st.mode = SWR_ON;
    endcase

    // Write channel: address and data may arrive in either order.
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_got = 1'b1;
      next_st.aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_got = 1'b1;
      next_st.w_d = s_axi_wdata;
      next_st.w_s = s_axi_wstrb;
    end
    if (st.aw_got && st.w_got) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = SWR_RESP_OK;
      if (st.aw_a == SWR_CTRL_OFS) begin
        if (st.w_s[0]) next_st.ctrl = st.w_d[7:0];
      end else if (st.aw_a == SWR_PINEN_OFS) begin
        if (st.w_s[0]) next_st.pinen[7:0] = st.w_d[7:0];
        if (st.w_s[1]) next_st.pinen[15:8] = st.w_d[15:8];
      end else if (st.aw_a != SWR_STAT_OFS) begin
        next_st.bresp = SWR_RESP_ERR;
      end
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    // Read channel: one-cycle accept, data valid in the same cycle.
    next_st.arready = 1'b0;
    if (s_axi_arvalid && !st.arready && !st.rvalid) begin
      next_st.arready = 1'b1;
      next_st.rvalid = 1'b1;
      next_st.rresp = SWR_RESP_OK;
      case (s_axi_araddr)
        SWR_CTRL_OFS: next_st.rdata = {24'h0, st.ctrl};
        SWR_STAT_OFS: next_st.rdata = stat_word;
        SWR_PINEN_OFS: next_st.rdata = {16'h0, st.pinen};
        default: begin
          next_st.rdata = 32'h0;
          next_st.rresp = SWR_RESP_ERR;
        end
      endcase
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end

    // Ready is registered from the next state, so it never shows high while a
    // word is held or a response waits, and the port comes straight from a flop.
    next_st.awready = !next_st.aw_got && !next_st.bvalid;
    next_st.wready = !next_st.w_got && !next_st.bvalid;
  end

  // Register the record; reset returns defaults and restarts at zero.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st <= '0;
      st.mode <= SWR_ON;
      st.ctrl <= SWR_CTRL_RST;
      st.pinen <= SWR_PINEN_RST;
      st.sysclk <= 1'b1;
      st.hs_en <= 1'b1;
      st.ls_en <= 1'b1;
      st.mem_en <= 1'b1;
      st.pc <= SWR_RESET_PC;
      // SRAM is cleared only for causes other than pin or watchdog reset.
      st.sram_clr <= !reset_keep_cause;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the record.
  // Every port is one field of the record, so none has logic in front of it.
  assign sys_clk_en = st.sysclk;
  assign high_speed_rc_osc_en = st.hs_en;
  assign low_speed_rc_osc_en = st.ls_en;
  assign programmable_code_memory_en = st.mem_en;
  assign sram_clear = st.sram_clr;
  assign resume_pulse = st.resume;
  assign restart_pc = st.pc;
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;

  // Checks on the sequencing; each label carries the tag of the rule it guards.
  // Residence in the low-power states and the wake delay that follows.
  a_down_osc_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st.mode == SWR_DOWN |-> !st.hs_en && !st.ls_en && !st.mem_en)
    else $error("oscillators or code memory on in power-down");
  a_save_osc_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(st.mode == SWR_SAVE) |-> st.hs_en && st.ls_en && !st.sysclk)
    else $error("light save changed oscillators");
  a_down_no_timer: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st.mode == SWR_DOWN && !pin_wake |=> st.mode == SWR_DOWN)
    else $error("power-down left without pin change");
  a_fast_limit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st.mode == SWR_WAKE && fast_boot |-> st.wlim == SWR_FAST_WAKE)
    else $error("fast boot did not force fast wake");
  a_sel_limit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(st.mode == SWR_WAKE) |-> st.wlim == (fast_sel ? SWR_FAST_WAKE : SWR_NORMAL_WAKE))
    else $error("wrong wake limit");
  a_resume_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st.resume |-> $past(st.wcnt) == st.wlim - 12'h001)
    else $error("resume before terminal count");
  a_resume_clk: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st.resume |-> st.sysclk && st.mode == SWR_ON && st.pc == SWR_RESET_PC)
    else $error("resume without clock");
  a_down_regs: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st.mode == SWR_DOWN && !st.aw_got |=> $stable(st.ctrl))
    else $error("register changed in power-down");
  // Entry into each low-power state, one cycle after the core's request.
  a_down_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st.mode == SWR_ON && down_req |=> st.mode == SWR_DOWN && !st.hs_en && !st.ls_en)
    else $error("power-down entry left an oscillator on");
  a_save_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st.mode == SWR_ON && save_req && !down_req |=> st.mode == SWR_SAVE && st.hs_en && st.ls_en)
    else $error("light save entry stopped an oscillator");
  // The wake counter runs off the low-speed oscillator, so both sources must run.
  a_wake_osc_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st.mode == SWR_WAKE |-> st.hs_en && st.ls_en)
    else $error("oscillator off while counting the wake delay");
  // Reset is not disabled here: the kept cause is judged while reset is held.
  a_keep_sram: assert property (@(posedge ref_clk)
    !rst_n && reset_keep_cause |=> !st.sram_clr)
    else $error("SRAM cleared for a pin or watchdog reset");
  // Main scenarios to be seen.
  c_down_wake: cover property (@(posedge ref_clk) disable iff (!rst_n)
    st.mode == SWR_DOWN ##1 st.mode == SWR_WAKE);
  c_save_timer: cover property (@(posedge ref_clk) disable iff (!rst_n)
    st.mode == SWR_SAVE && timer_match && timer_off_sysclk);
  c_save_cmp: cover property (@(posedge ref_clk) disable iff (!rst_n)
    st.mode == SWR_SAVE && cmp_event && st.ctrl[SWR_CMPWK_BIT]);
  c_resume: cover property (@(posedge ref_clk) disable iff (!rst_n) st.resume);
endmodule
`default_nettype wire

// >>> swr_core_model.sv
// Behavioural model of the processor core and pin setup around the controller.
// Assumes the bench hands it sleep commands by non-blocking assignment.
`timescale 1ns/10ps
`default_nettype none
module swr_core_model
  import swr_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Bench commands: bit 0 light save, bit 1 deep down.
  input wire logic [1:0] sleep_cmd,
  input wire logic [SWR_NPIN-1:0] in_mask,
  // Controller side.
  input wire logic sys_clk_en,
  output logic save_req,
  output logic down_req,
  output logic [SWR_NPIN-1:0] pin_is_input
);
  // Software sets wake pins to input before it sleeps.
  assign pin_is_input = in_mask;
  // A gated core executes nothing, so it can only sleep while clocked.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      save_req <= 1'b0;
      down_req <= 1'b0;
    end else begin
      save_req <= sleep_cmd[0] & sys_clk_en;
      down_req <= sleep_cmd[1] & sys_clk_en;
    end
  end
endmodule
`default_nettype wire

// >>> swr_ctrl_tb_top.sv
// Self-checking bench for the sleep, wake-up and reset controller.
// Assumes the core model file and the package are compiled first.
`timescale 1ns/10ps
`default_nettype none
module swr_ctrl_tb_top;
  import swr_pkg::*;
  // Stimulus, all given a value at time zero.
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic fast_boot = 1'b0;
  logic keep = 1'b0;
  logic [1:0] cmd = 2'h0;
  logic [15:0] mask = 16'h0000;
  logic [15:0] pins = 16'h0000;
  logic tmatch = 1'b0;
  logic toff = 1'b0;
  logic cmp = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  // Design outputs.
  logic save_req, down_req, sys_en, hs_en, ls_en, mem_en, sram_clr, resume;
  logic awready, wready, bvalid, arready, rvalid;
  logic [15:0] pin_in;
  logic [15:0] pc;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [1:0] r;
  int errors = 0;
  int total_checks = 0;
  // One fast wake lasts this many reference cycles.
  int fast_cyc = int'(SWR_FAST_WAKE) * (int'(SWR_LS_DIV) + 1);

  always #10 ref_clk = ~ref_clk;

  swr_core_model core (.ref_clk(ref_clk), .rst_n(rst_n), .sleep_cmd(cmd), .in_mask(mask),
    .sys_clk_en(sys_en), .save_req(save_req), .down_req(down_req), .pin_is_input(pin_in));

  swr_ctrl uut (.ref_clk(ref_clk), .rst_n(rst_n), .fast_boot(fast_boot),
    .reset_keep_cause(keep), .save_req(save_req), .down_req(down_req), .wake_pins(pins),
    .pin_is_input(pin_in), .timer_match(tmatch), .timer_off_sysclk(toff), .cmp_event(cmp),
    .sys_clk_en(sys_en), .high_speed_rc_osc_en(hs_en), .low_speed_rc_osc_en(ls_en),
    .programmable_code_memory_en(mem_en), .sram_clear(sram_clr), .resume_pulse(resume),
    .restart_pc(pc), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // Prints the verdict and ends the run.
  task automatic close_out();
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Compares one value and counts it.
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Write; address and data go out together and each drops once taken.
  // It sets no limit of its own: only the watchdog ends a hung wait.
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", 32'(SWR_RESP_OK), 32'(bresp));
    @(posedge ref_clk);
  endtask

  // Read; data and response are taken at the edge that sees rvalid.
  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
      v = rdata;
      rs = rresp;
    end while (!rvalid);
    rready <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Asks the core for one sleep instruction and lets it land.
  task automatic sleep(input logic [1:0] k);
    cmd <= k;
    @(posedge ref_clk);
    cmd <= 2'h0;
    tick(3);
  endtask

  // Counts cycles to the resume pulse; a fast wake must land near its count.
  task automatic wake_chk(input string name);
    int n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!resume && n < 5000);
    chk(name, 32'h1, 32'(n >= fast_cyc && n <= fast_cyc + 40));
  endtask

  initial begin
    tick(11);
    #1 chk("sram_clear", 32'h1, 32'(sram_clr));
    @(posedge ref_clk);
    rst_n <= 1'b1;
    tick(2);
    chk("enables", 32'hF, 32'({sys_en, hs_en, ls_en, mem_en}));
    chk("restart_pc", 32'(SWR_RESET_PC), 32'(pc));
    chk("sram_clear_off", 32'h0, 32'(sram_clr));
    rd(SWR_CTRL_OFS, d, r);
    chk("ctrl", 32'(SWR_CTRL_RST), d);
    rd(4'hC, d, r);
    chk("bad_resp", 32'(SWR_RESP_ERR), 32'(r));
    // Deep sleep: pin 0 is a wake input, pin 1 is enabled but an output.
    wr(SWR_PINEN_OFS, 32'h0000_0003);
    wr(SWR_CTRL_OFS, 32'h0000_0020);
    mask <= 16'h0001;
    sleep(2'h2);
    chk("down_en", 32'h0, 32'({sys_en, hs_en, ls_en, mem_en}));
    pins <= 16'h0002;
    tmatch <= 1'b1;
    toff <= 1'b1;
    cmp <= 1'b1;
    tick(300);
    chk("down_hold", 32'h0, 32'(sys_en));
    tmatch <= 1'b0;
    cmp <= 1'b0;
    pins <= 16'h0003;
    wake_chk("fast_pin");
    tick(2);
    chk("resumed", 32'hF, 32'({sys_en, hs_en, ls_en, mem_en}));
    rd(SWR_PINEN_OFS, d, r);
    chk("pinen_kept", 32'h3, d);
    // Light save: the system clock stops, both oscillators run; the timer wakes it.
    sleep(2'h1);
    chk("save_en", 32'h3, 32'({sys_en, hs_en, ls_en}));
    tmatch <= 1'b1;
    wake_chk("timer_wake");
    tmatch <= 1'b0;
    wr(SWR_CTRL_OFS, 32'h0000_0060);
    sleep(2'h1);
    cmp <= 1'b1;
    wake_chk("cmp_wake");
    cmp <= 1'b0;
    // The build option forces fast wake although bit 5 is clear.
    fast_boot <= 1'b1;
    wr(SWR_CTRL_OFS, 32'h0000_0000);
    sleep(2'h2);
    pins <= 16'h0000;
    wake_chk("forced_fast");
    // Normal wake is far longer; a second reset cuts it short.
    fast_boot <= 1'b0;
    tick(2);
    sleep(2'h2);
    pins <= 16'h0001;
    tick(4000);
    chk("normal_hold", 32'h0, 32'(sys_en));
    keep <= 1'b1;
    rst_n <= 1'b0;
    tick(11);
    #1 chk("sram_keep", 32'h0, 32'(sram_clr));
    @(posedge ref_clk);
    rst_n <= 1'b1;
    tick(2);
    chk("enables2", 32'hF, 32'({sys_en, hs_en, ls_en, mem_en}));
    rd(SWR_PINEN_OFS, d, r);
    chk("pinen_rst", 32'(SWR_PINEN_RST), d);
    close_out();
  end

  // Cuts a hang short; the tests need about 16,000 cycles.
  initial begin
    tick(60000);
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
